// ---- logic/ccgb_pkg.sv ----
// Purpose: constants for the colour channel gain bank
// Assumes: register index space of the serial register port, 16-bit data
// Notes: gain fields are 12 bits; bits 15:12 read as zero
// Operation
// - digital bits 11:9 each double the gain
// - analog bits 8:7 each double initial gain
// - bits 6:0 times 1/32, reset 0x20
// - analog and digital bits reset to zero
// - global gain read returns first-green register
`default_nettype none
package ccgb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int GAIN_W = 12;
    localparam int TOTAL_W = 12;
    localparam logic [ADDR_W-1:0] BLUE_GAIN_IDX = 8'h2c;
    localparam logic [ADDR_W-1:0] RED_GAIN_IDX = 8'h2d;
    localparam logic [ADDR_W-1:0] SECOND_GREEN_CHANNEL_GAIN_IDX = 8'h2e;
    localparam logic [ADDR_W-1:0] ALL_GAIN_IDX = 8'h3f;
    localparam int DIG_MSB = 11;
    localparam int DIG_LSB = 9;
    localparam int ANA_MSB = 8;
    localparam int ANA_LSB = 7;
    localparam int INIT_MSB = 6;
    localparam int INIT_LSB = 0;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h020;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;
    typedef enum logic [1:0] {CCGB_BLUE, CCGB_RED, CCGB_GREEN2} ccgb_chan_t;
endpackage
`default_nettype wire

// ---- logic/ccgb_gain_decode.sv ----
// Purpose: turn one 12-bit gain code into a linear gain
// Assumes: result in units of 1/32 (0x20 is unity)
// Notes: combinational, pure shift since every stage is a power of two
`timescale 1ns/1ps
`default_nettype none
module ccgb_gain_decode
    import ccgb_pkg::*;
(
    // gain code
    input wire logic [ccgb_pkg::GAIN_W-1:0] code_i,
    // decoded gains
    output logic [ccgb_pkg::TOTAL_W-1:0] analog_o,
    output logic [ccgb_pkg::TOTAL_W-1:0] total_o
);
    import ccgb_pkg::*;

    wire logic [6:0] init_gain;
    wire logic [1:0] ana_shift;
    wire logic [2:0] dig_shift;
    wire logic [2:0] all_shift;
    wire logic [TOTAL_W-1:0] init_wide;

    assign init_gain = code_i[INIT_MSB:INIT_LSB];
    assign ana_shift = 2'(code_i[ANA_LSB]) + 2'(code_i[ANA_MSB]);
    assign dig_shift = 3'(code_i[DIG_LSB]) + 3'(code_i[DIG_LSB+1]) + 3'(code_i[DIG_MSB]);
    assign all_shift = 3'(ana_shift) + dig_shift;
    assign init_wide = TOTAL_W'(init_gain);
    assign analog_o = init_wide << ana_shift;
    assign total_o = init_wide << all_shift;
endmodule
`default_nettype wire

// ---- logic/ccgb_bank.sv ----
// Purpose: blue, red and second-green gain registers with frame-synced copies
// Assumes: register port is the word side of the two-wire serial engine,
//          frame_start_i is a one-cycle pulse on ref_clk_i
// Notes: writes land in a staging copy; the working copy loads at frame start
//        a global write loads all three staging registers
`timescale 1ns/1ps
`default_nettype none
module ccgb_bank
    import ccgb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // register port from the serial engine
    input wire logic [ccgb_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [ccgb_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [ccgb_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // first-green register held elsewhere
    input wire logic [ccgb_pkg::GAIN_W-1:0] green1_gain_i,
    // frame timing
    input wire logic frame_start_i,
    // working gain codes, loaded at frame start
    output logic [ccgb_pkg::GAIN_W-1:0] blue_gain_o,
    output logic [ccgb_pkg::GAIN_W-1:0] red_gain_o,
    output logic [ccgb_pkg::GAIN_W-1:0] second_green_channel_gain_o,
    // decoded analog and total gains, 1/32 units
    output logic [ccgb_pkg::TOTAL_W-1:0] blue_analog_o,
    output logic [ccgb_pkg::TOTAL_W-1:0] red_analog_o,
    output logic [ccgb_pkg::TOTAL_W-1:0] green2_analog_o,
    output logic [ccgb_pkg::TOTAL_W-1:0] blue_total_o,
    output logic [ccgb_pkg::TOTAL_W-1:0] red_total_o,
    output logic [ccgb_pkg::TOTAL_W-1:0] green2_total_o,
    // pending writes not yet applied
    output logic update_pending_o
);
    import ccgb_pkg::*;

    // zero-extend a gain code to the register word
    function automatic logic [DATA_W-1:0] widen(input logic [GAIN_W-1:0] g);
        widen = DATA_W'(g);
    endfunction

    // value loaded at frame start: a write in the same cycle wins
    function automatic logic [GAIN_W-1:0] frame_load(
        input logic wr,
        input logic [GAIN_W-1:0] wdata,
        input logic [GAIN_W-1:0] staged
    );
        frame_load = wr ? wdata : staged;
    endfunction

    // index names this channel or the global alias
    function automatic logic chan_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] idx
    );
        chan_hit = (addr == idx) || (addr == ALL_GAIN_IDX);
    endfunction

    logic [GAIN_W-1:0] blue_channel_gain;
    logic [GAIN_W-1:0] red_channel_gain;
    logic [GAIN_W-1:0] second_green_channel_gain;
    logic [GAIN_W-1:0] blue_work;
    logic [GAIN_W-1:0] red_work;
    logic [GAIN_W-1:0] green2_work;
    logic pending;
    logic [DATA_W-1:0] rdata;
    logic rvalid;

    wire logic hit_blue;
    wire logic hit_red;
    wire logic hit_green2;
    wire logic hit_all;
    wire logic wr_blue;
    wire logic wr_red;
    wire logic wr_green2;
    wire logic any_wr;
    wire logic [GAIN_W-1:0] wr_gain;
    wire logic [DATA_W-1:0] next_rdata;
    wire logic [GAIN_W-1:0] next_blue_work;
    wire logic [GAIN_W-1:0] next_red_work;
    wire logic [GAIN_W-1:0] next_green2_work;
    wire logic next_pending;
    wire logic next_rvalid;

    // address decode
    assign hit_blue = reg_addr_i == BLUE_GAIN_IDX;
    assign hit_red = reg_addr_i == RED_GAIN_IDX;
    assign hit_green2 = reg_addr_i == SECOND_GREEN_CHANNEL_GAIN_IDX;
    assign hit_all = reg_addr_i == ALL_GAIN_IDX;
    // a global write sets every colour channel here
    assign wr_blue = reg_wr_i & chan_hit(reg_addr_i, BLUE_GAIN_IDX);
    assign wr_red = reg_wr_i & chan_hit(reg_addr_i, RED_GAIN_IDX);
    assign wr_green2 = reg_wr_i & chan_hit(reg_addr_i, SECOND_GREEN_CHANNEL_GAIN_IDX);
    assign any_wr = wr_blue | wr_red | wr_green2;
    assign wr_gain = reg_wdata_i[GAIN_W-1:0];

    // working values offered at each frame start
    assign next_blue_work = frame_load(wr_blue, wr_gain, blue_channel_gain);
    assign next_red_work = frame_load(wr_red, wr_gain, red_channel_gain);
    assign next_green2_work = frame_load(wr_green2, wr_gain, second_green_channel_gain);

    // pending: a write in the frame-start cycle is applied at once
    assign next_pending = frame_start_i ? 1'b0 : (any_wr | pending);
    assign next_rvalid = reg_rd_i;

    // read mux, upper bits zero
    assign next_rdata = hit_blue ? widen(blue_channel_gain) :
                        hit_red ? widen(red_channel_gain) :
                        hit_green2 ? widen(second_green_channel_gain) :
                        hit_all ? widen(green1_gain_i) :
                        UNMAPPED_READ;

    // blue staging register written by software
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            blue_channel_gain <= GAIN_RESET;
        end else if (wr_blue) begin
            blue_channel_gain <= wr_gain;
        end
    end

    // red staging register written by software
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            red_channel_gain <= GAIN_RESET;
        end else if (wr_red) begin
            red_channel_gain <= wr_gain;
        end
    end

    // second-green staging register written by software
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            second_green_channel_gain <= GAIN_RESET;
        end else if (wr_green2) begin
            second_green_channel_gain <= wr_gain;
        end
    end

    // blue working copy, changes only at frame start
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            blue_work <= GAIN_RESET;
        end else if (frame_start_i) begin
            blue_work <= next_blue_work;
        end
    end

    // red working copy, changes only at frame start
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            red_work <= GAIN_RESET;
        end else if (frame_start_i) begin
            red_work <= next_red_work;
        end
    end

    // second-green working copy, changes only at frame start
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            green2_work <= GAIN_RESET;
        end else if (frame_start_i) begin
            green2_work <= next_green2_work;
        end
    end

    // pending flag for software polling
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pending <= 1'b0;
        end else begin
            pending <= next_pending;
        end
    end

    // read data, captured on the strobe and held until the next read
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rdata <= UNMAPPED_READ;
        end else if (reg_rd_i) begin
            rdata <= next_rdata;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= next_rvalid;
        end
    end

    ccgb_gain_decode u_blue_dec (
        .code_i(blue_work),
        .analog_o(blue_analog_o),
        .total_o(blue_total_o)
    );

    ccgb_gain_decode u_red_dec (
        .code_i(red_work),
        .analog_o(red_analog_o),
        .total_o(red_total_o)
    );

    ccgb_gain_decode u_green2_dec (
        .code_i(green2_work),
        .analog_o(green2_analog_o),
        .total_o(green2_total_o)
    );

    // outputs straight from flip-flops
    assign blue_gain_o = blue_work;
    assign red_gain_o = red_work;
    assign second_green_channel_gain_o = green2_work;
    assign update_pending_o = pending;
    assign reg_rdata_o = rdata;
    assign reg_rvalid_o = rvalid;
endmodule
`default_nettype wire

// ---- dv/ccgb_bank_properties.sv ----
// Purpose: port checks for the gain bank
// Assumes: one clock, sync low reset
// Notes: bound to ccgb_bank
`timescale 1ns/1ps
`default_nettype none
module ccgb_bank_properties
    import ccgb_pkg::*;
(
    // clock, reset, register port
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // gains and frame
    input wire logic [11:0] green1_gain_i,
    input wire logic frame_start_i,
    input wire logic [11:0] blue_gain_o,
    input wire logic [11:0] blue_analog_o,
    input wire logic [11:0] blue_total_o,
    input wire logic update_pending_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic [11:0] init = {5'h00, blue_gain_o[6:0]};
    wire logic [1:0] an = 2'(blue_gain_o[8]) + 2'(blue_gain_o[7]);
    wire logic [2:0] dn = 3'(blue_gain_o[11]) + 3'(blue_gain_o[10]) + 3'(blue_gain_o[9]);
    wire logic bw = reg_wr_i && reg_addr_i inside {BLUE_GAIN_IDX, ALL_GAIN_IDX};
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("no read answer");
    a_global_read: assert property (reg_rd_i && reg_addr_i == ALL_GAIN_IDX |=>
        reg_rdata_o == {4'h0, $past(green1_gain_i)}) else $error("bad global read");
    a_analog_gain: assert property (blue_analog_o == init << an)
        else $error("bad analog gain");
    a_total_gain: assert property (blue_total_o == blue_analog_o << dn)
        else $error("bad total gain");
    a_reset_unity: assert property ($rose(nrst_i) |-> blue_gain_o == GAIN_RESET)
        else $error("bad reset gain");
    a_hold_frame: assert property (!frame_start_i |=> $stable(blue_gain_o))
        else $error("gain moved mid frame");
    a_frame_apply: assert property (bw && frame_start_i |=>
        blue_gain_o == $past(reg_wdata_i[11:0])) else $error("write not applied");
    a_pending_flag: assert property (bw && !frame_start_i |=> update_pending_o)
        else $error("pending not set");
    a_pending_clear: assert property (frame_start_i |=> !update_pending_o)
        else $error("pending not cleared");
    c_global_read: cover property (reg_rd_i && reg_addr_i == ALL_GAIN_IDX);
    c_frame_write: cover property (bw && frame_start_i);
    c_full_gain: cover property (dn == 3'h3 && an == 2'h2);
endmodule
bind ccgb_bank ccgb_bank_properties chk(.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .green1_gain_i, .frame_start_i,
    .blue_gain_o, .blue_analog_o, .blue_total_o, .update_pending_o);
`default_nettype wire

// ---- dv/ccgb_bank_test.sv ----
// Purpose: self-checking bench for the gain bank
// Assumes: inputs driven on the falling edge
// Notes: integer model of staged and working gains
`timescale 1ns/1ps
`default_nettype none
module ccgb_bank_test;
    import ccgb_pkg::*;
    logic ref_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, frame_start_i = 0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    logic [11:0] green1_gain_i = 12'h000, g[3], an[3], tt[3];
    logic reg_rvalid_o, update_pending_o;
    int errors = 0, checks_done = 0, pend, stage[3], work[3];
    logic [7:0] amap[5] = '{8'h2c, 8'h2d, 8'h2e, 8'h3f, 8'h10};
    always #2 ref_clk_i = ~ref_clk_i;
    ccgb_bank dut(.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .reg_rvalid_o, .green1_gain_i, .frame_start_i, .blue_gain_o(g[0]),
        .red_gain_o(g[1]), .second_green_channel_gain_o(g[2]), .blue_analog_o(an[0]), .red_analog_o(an[1]),
        .green2_analog_o(an[2]), .blue_total_o(tt[0]), .red_total_o(tt[1]),
        .green2_total_o(tt[2]), .update_pending_o);
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] tot(input int c, input int dig);
        int s;
        s = c[8] + c[7] + dig * (c[11] + c[10] + c[9]);
        return 16'((c & 127) << s);
    endfunction
    task automatic chkall();
        for (int i = 0; i < 3; i++) begin
            chk(g[i], work[i]);
            chk(an[i], tot(work[i], 0));
            chk(tt[i], tot(work[i], 1));
        end
        chk(update_pending_o, pend);
        chk(reg_rvalid_o, 0);
    endtask
    task automatic drv(input logic [7:0] a, input logic [15:0] d, input logic w, r, fs);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = w;
        reg_rd_i = r;
        frame_start_i = fs;
        @(negedge ref_clk_i);
    endtask
    task automatic op(input logic [7:0] a, input logic [15:0] d, input logic w, fs);
        drv(a, d, w, 0, fs);
        for (int i = 0; i < 3; i++) begin
            if (w && (a == ALL_GAIN_IDX || a == BLUE_GAIN_IDX + i)) stage[i] = d[11:0];
        end
        pend = fs ? 0 : w ? 1 : pend;
        if (fs) work = stage;
        chkall();
    endtask
    task automatic rd(input logic [7:0] a);
        int e;
        e = a == ALL_GAIN_IDX ? green1_gain_i : UNMAPPED_READ;
        if (a >= 8'h2c && a <= 8'h2e) e = stage[a - 8'h2c];
        drv(a, 16'h0000, 0, 1, 0);
        chk(reg_rvalid_o, 1);
        chk(reg_rdata_o, e);
    endtask
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    initial begin
        void'($urandom(37));
        repeat (2) begin
            drv(8'h00, 16'h0000, 0, 0, 0);
            nrst_i = 0;
            repeat (20) @(negedge ref_clk_i);
            nrst_i = 1;
            stage = '{32, 32, 32};
            work = stage;
            pend = 0;
            chkall();
            for (int i = 0; i < 5; i++) rd(amap[i]);
            op(8'h2c, 16'hffff, 1, 0);
            rd(8'h2c);
            op(8'h00, 16'h0000, 0, 1);
            op(8'h3f, 16'h0e40, 1, 1);
            repeat (40) begin
                green1_gain_i = 12'($urandom);
                op(amap[$urandom % 4], 16'($urandom), 1, 1'($urandom));
                rd(amap[$urandom % 5]);
                if ($urandom % 2) op(8'h00, 16'h0000, 0, 1);
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
